/* hdl/ftm_pkg.sv */
// constants for the fan tachometer monitor: port map, indexes, fields, timing
// assumes a 250 MHz core clock and a host that issues byte-wide i/o strobes
package ftm_pkg;
  // configuration port pair addresses
  localparam logic [15:0] FTM_CFG_INDEX_ADDR = 16'h002E;
  localparam logic [15:0] FTM_CFG_DATA_ADDR  = 16'h002F;
  // configuration mode keys written to the index port
  localparam logic [7:0]  FTM_CFG_ENTER_KEY  = 8'h55;
  localparam logic [7:0]  FTM_CFG_EXIT_KEY   = 8'hAA;
  // configuration register indexes
  localparam logic [7:0]  FTM_CFG_LDN_IDX    = 8'h07;
  localparam logic [7:0]  FTM_CFG_BASE_HI    = 8'h60;
  localparam logic [7:0]  FTM_CFG_BASE_LO    = 8'h61;
  // logical device number of the runtime block
  localparam logic [7:0]  FTM_RUNTIME_LDN    = 8'h0A;
  // monitor index port sits at runtime base plus this offset, data port one above
  localparam logic [15:0] FTM_RUNTIME_MONITOR_OFFSET = 16'h0070;
  // monitor register indexes
  localparam logic [7:0]  FTM_FAN_SPEED_COUNT_INDEX     = 8'h28;
  localparam logic [7:0]  FTM_FAN_SPEED_COUNT_HI_INDEX  = 8'h29;
  localparam logic [7:0]  FTM_MONITOR_START_CONTROL_INDEX = 8'h40;
  // field positions and reset values
  localparam int          FTM_START_BIT      = 0;
  localparam logic [7:0]  FTM_START_CTRL_RST = 8'h00;
  localparam logic [15:0] FTM_COUNT_STALLED  = 16'hFFFF;
  localparam logic [2:0]  FTM_EDGES_PER_REV  = 3'h5;
  // timing: reference tick rate derived from the core clock
  localparam longint      FTM_CLK_HZ         = 250_000_000;
  localparam longint      FTM_REF_HZ         = 90_000;
  localparam int          FTM_REF_DIV        = int'(FTM_CLK_HZ / FTM_REF_HZ);
endpackage

/* hdl/ftm_meas_if.sv */
// carrier between the tachometer counter and the register front end
// assumes a single clock domain shared by both ends
`timescale 1ns/1ps
interface ftm_meas_if;
  logic        enable;  // monitoring started
  logic        valid;   // one-cycle pulse: new measurement ready
  logic [15:0] count;   // measured reference periods, saturating
  modport counter (input enable, output valid, output count);
  modport host    (output enable, input valid, input count);
endinterface

/* hdl/ftm_tach_counter.sv */
// tachometer edge counter: counts reference periods across five tach edges
// assumes the tach input is already synchronous to the clock
`timescale 1ns/1ps
module ftm_tach_counter
  import ftm_pkg::*;
#(
  parameter int REF_DIV = FTM_REF_DIV
) (
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  input  wire logic  tach_i,
  ftm_meas_if.counter meas
);
  logic [11:0] div_q;     // reference divider
  logic        tick;      // one reference period elapsed
  logic        tach_q;    // previous tach level
  logic        edge_seen; // any tach transition
  logic [2:0]  edges_q;   // edges in current window
  logic [15:0] cnt_q;     // reference periods in window
  logic        done;      // fifth edge reached
  logic        sat_done;  // saturated with no fifth edge
  logic        valid_q;
  logic [15:0] count_q;

  assign tick      = (div_q == 12'(REF_DIV - 1));
  assign edge_seen = tach_i ^ tach_q;
  assign done      = edge_seen && (edges_q == FTM_EDGES_PER_REV - 3'h1);
  assign sat_done  = tick && (cnt_q == FTM_COUNT_STALLED) && !done;
  assign meas.valid = valid_q;
  assign meas.count = count_q;

  // reference divider, free running
  always_ff @(posedge clk_i) begin
    if (rst_i || tick) begin
      div_q <= 12'h000;
    end else begin
      div_q <= div_q + 12'h001;
    end
  end

  // previous tach level for edge detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tach_q <= 1'b0;
    end else begin
      tach_q <= tach_i;
    end
  end

  // RULE5: count periods over five edges
  always_ff @(posedge clk_i) begin
    if (rst_i || !meas.enable || done || sat_done) begin
      edges_q <= 3'h0;
    end else if (edge_seen) begin
      edges_q <= edges_q + 3'h1;
    end
  end

  // RULE10: saturate instead of wrapping
  always_ff @(posedge clk_i) begin
    if (rst_i || !meas.enable || done || sat_done) begin
      cnt_q <= 16'h0000;
    end else if (tick && cnt_q != FTM_COUNT_STALLED) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // publish a finished or stalled measurement
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      valid_q <= 1'b0;
      count_q <= FTM_COUNT_STALLED;
    end else begin
      valid_q <= meas.enable && (done || sat_done);
      // RULE4: stalled fan reports all ones
      if (meas.enable && sat_done) begin
        count_q <= FTM_COUNT_STALLED;
      end else if (meas.enable && done) begin
        count_q <= cnt_q;
      end
    end
  end

  // counter never wraps from the top value
  a_cnt_no_wrap: assert property (@(posedge clk_i) disable iff (rst_i) // RULE10
    meas.enable && cnt_q == FTM_COUNT_STALLED && !done && !sat_done
      |=> cnt_q == FTM_COUNT_STALLED)
    else $error("count wrapped past its top value");

  // saturation publishes the stalled value
  a_stall_publish: assert property (@(posedge clk_i) disable iff (rst_i) // RULE4
    meas.enable && sat_done |=> valid_q && count_q == FTM_COUNT_STALLED)
    else $error("stalled fan not reported as all ones");

  // fifth edge publishes the window count
  a_fifth_edge: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
    meas.enable && done && !sat_done |=> valid_q && count_q == $past(cnt_q))
    else $error("window count not published on fifth edge");
endmodule

/* hdl/ftm_top.sv */
// fan tachometer monitor: configuration and runtime port pairs plus count latch
// assumes host i/o strobes are one-cycle pulses synchronous to CLOCK_I
//
// Contract
// RULE1: sixteen-bit speed count read as two bytes
// RULE2: reading one byte freezes the other byte; a measurement landing in the first read's cycle still updates both bytes
// RULE3: host reads low byte before high byte
// RULE4: all ones means fan stationary
// RULE5: count reference periods over five tach edges
// RULE6: start bit zero of index 40h
// RULE7: count low at 28h, high at 29h
// RULE8: 55h enters, AAh leaves configuration mode
// RULE9: base readable at 60h/61h for device 0Ah
// RULE10: counter saturates rather than wrapping
// RULE11: update count after measurement unless held
`timescale 1ns/1ps
module ftm_top
  import ftm_pkg::*;
#(
  parameter logic [15:0] RUNTIME_BASE = 16'h0A00,   // reset runtime base address
  parameter int          REF_DIV      = FTM_REF_DIV  // core clocks per reference period
) (
  input  wire logic        CLOCK_I,
  input  wire logic        RST_I,
  input  wire logic [15:0] IO_ADDR_I,
  input  wire logic [7:0]  IO_WDATA_I,
  input  wire logic        IO_WR_I,
  input  wire logic        IO_RD_I,
  input  wire logic        TACH_I,
  output logic      [7:0]  IO_RDATA_O,
  output logic             MONITOR_ON_O
);
  ftm_meas_if meas ();

  logic        cfg_mode_q;   // configuration mode active
  logic [7:0]  cfg_idx_q;    // configuration index
  logic [7:0]  ldn_q;        // selected logical device
  logic [15:0] base_q;       // runtime register base
  logic [7:0]  mon_idx_q;    // monitor index
  logic [7:0]  start_ctrl_q; // monitor start control register
  logic [15:0] count_q;      // host-visible speed count
  logic        hold_q;       // one byte read, other byte frozen
  logic        first_hi_q;   // the byte read first was the high one
  logic [7:0]  rdata_q;
  logic        wr_cfg_idx, wr_cfg_dat, rd_cfg_dat;
  logic        wr_mon_idx, wr_mon_dat, rd_mon_dat;
  logic        rd_lo, rd_hi;
  logic [15:0] mon_base;

  // address match shared by every port decode
  function automatic logic hit(input logic [15:0] a, input logic [15:0] t);
    return a == t;
  endfunction

  assign mon_base   = base_q + FTM_RUNTIME_MONITOR_OFFSET;
  assign wr_cfg_idx = IO_WR_I && hit(IO_ADDR_I, FTM_CFG_INDEX_ADDR);
  assign wr_cfg_dat = IO_WR_I && cfg_mode_q && hit(IO_ADDR_I, FTM_CFG_DATA_ADDR);
  assign rd_cfg_dat = IO_RD_I && cfg_mode_q && hit(IO_ADDR_I, FTM_CFG_DATA_ADDR);
  assign wr_mon_idx = IO_WR_I && hit(IO_ADDR_I, mon_base);
  assign wr_mon_dat = IO_WR_I && hit(IO_ADDR_I, mon_base + 16'h0001);
  assign rd_mon_dat = IO_RD_I && hit(IO_ADDR_I, mon_base + 16'h0001);
  // RULE7: count byte index decode
  assign rd_lo      = rd_mon_dat && mon_idx_q == FTM_FAN_SPEED_COUNT_INDEX;
  assign rd_hi      = rd_mon_dat && mon_idx_q == FTM_FAN_SPEED_COUNT_HI_INDEX;
  assign meas.enable  = start_ctrl_q[FTM_START_BIT];
  assign MONITOR_ON_O = start_ctrl_q[FTM_START_BIT];
  assign IO_RDATA_O   = rdata_q;

  ftm_tach_counter #(
    .REF_DIV (REF_DIV)
  ) u_counter (
    .clk_i  (CLOCK_I),
    .rst_i  (RST_I),
    .tach_i (TACH_I),
    .meas   (meas.counter)
  );

  // RULE8: key writes open and close configuration
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      cfg_mode_q <= 1'b0;
    end else if (wr_cfg_idx && IO_WDATA_I == FTM_CFG_ENTER_KEY) begin
      cfg_mode_q <= 1'b1;
    end else if (wr_cfg_idx && IO_WDATA_I == FTM_CFG_EXIT_KEY) begin
      cfg_mode_q <= 1'b0;
    end
  end

  // configuration index and device select
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      cfg_idx_q <= 8'h00;
      ldn_q     <= 8'h00;
    end else begin
      if (wr_cfg_idx && cfg_mode_q) begin
        cfg_idx_q <= IO_WDATA_I;
      end
      if (wr_cfg_dat && cfg_idx_q == FTM_CFG_LDN_IDX) begin
        ldn_q <= IO_WDATA_I;
      end
    end
  end

  // runtime base, writable while the runtime device is selected
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      base_q <= RUNTIME_BASE;
    end else if (wr_cfg_dat && ldn_q == FTM_RUNTIME_LDN) begin
      if (cfg_idx_q == FTM_CFG_BASE_HI) begin
        base_q[15:8] <= IO_WDATA_I;
      end else if (cfg_idx_q == FTM_CFG_BASE_LO) begin
        base_q[7:0] <= IO_WDATA_I;
      end
    end
  end

  // monitor index port
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      mon_idx_q <= 8'h00;
    end else if (wr_mon_idx) begin
      mon_idx_q <= IO_WDATA_I;
    end
  end

  // RULE6: start control written through the data port
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      start_ctrl_q <= FTM_START_CTRL_RST;
    end else if (wr_mon_dat && mon_idx_q == FTM_MONITOR_START_CONTROL_INDEX) begin
      start_ctrl_q <= IO_WDATA_I;
    end
  end

  // RULE2: first byte read freezes the pair from the next cycle until the other byte
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      hold_q     <= 1'b0;
      first_hi_q <= 1'b0;
    end else if (!hold_q && (rd_lo || rd_hi)) begin
      hold_q     <= 1'b1;
      first_hi_q <= rd_hi;
    end else if (hold_q && ((rd_hi && !first_hi_q) || (rd_lo && first_hi_q))) begin
      hold_q     <= 1'b0;
    end
  end

  // RULE11: new measurement lands only while unheld
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      count_q <= FTM_COUNT_STALLED;
    end else if (meas.valid && !hold_q) begin
      count_q <= meas.count;
    end
  end

  // RULE1: read data mux, one byte per access
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      rdata_q <= 8'h00;
    end else if (rd_cfg_dat) begin
      // RULE9: base bytes visible for the runtime device
      if (ldn_q == FTM_RUNTIME_LDN && cfg_idx_q == FTM_CFG_BASE_HI) begin
        rdata_q <= base_q[15:8];
      end else if (ldn_q == FTM_RUNTIME_LDN && cfg_idx_q == FTM_CFG_BASE_LO) begin
        rdata_q <= base_q[7:0];
      end else if (cfg_idx_q == FTM_CFG_LDN_IDX) begin
        rdata_q <= ldn_q;
      end else begin
        rdata_q <= 8'h00;
      end
    end else if (rd_mon_dat) begin
      if (rd_lo) begin
        rdata_q <= count_q[7:0];
      end else if (rd_hi) begin
        rdata_q <= count_q[15:8];
      end else if (mon_idx_q == FTM_MONITOR_START_CONTROL_INDEX) begin
        rdata_q <= start_ctrl_q;
      end else begin
        rdata_q <= 8'h00;
      end
    end else if (IO_RD_I) begin
      rdata_q <= 8'h00;
    end
  end

  // held count does not move
  a_hold_freezes: assert property (@(posedge CLOCK_I) disable iff (RST_I) // RULE2
    hold_q |=> count_q == $past(count_q))
    else $error("count changed while held");

  // low byte read first arms the latch
  a_low_arms: assert property (@(posedge CLOCK_I) disable iff (RST_I) // RULE3
    !hold_q && rd_lo |=> hold_q && !first_hi_q && IO_RDATA_O == $past(count_q[7:0]))
    else $error("low byte read did not latch the high byte");

  // high byte after low releases and returns the frozen byte
  a_high_release: assert property (@(posedge CLOCK_I) disable iff (RST_I) // RULE1
    hold_q && !first_hi_q && rd_hi |=> !hold_q && IO_RDATA_O == $past(count_q[15:8]))
    else $error("high byte read did not release the latch");

  // unheld measurement is copied next cycle
  a_count_update: assert property (@(posedge CLOCK_I) disable iff (RST_I) // RULE11
    meas.valid && !hold_q |=> count_q == $past(meas.count))
    else $error("measurement not copied to count");

  // start bit follows a data write at the start index
  a_start_write: assert property (@(posedge CLOCK_I) disable iff (RST_I) // RULE6
    wr_mon_dat && mon_idx_q == FTM_MONITOR_START_CONTROL_INDEX
      |=> MONITOR_ON_O == $past(IO_WDATA_I[FTM_START_BIT]))
    else $error("start bit did not follow its write");

  // entry and exit keys
  a_cfg_keys: assert property (@(posedge CLOCK_I) disable iff (RST_I) // RULE8
    wr_cfg_idx |=> cfg_mode_q == ($past(IO_WDATA_I) == FTM_CFG_ENTER_KEY ? 1'b1 :
      ($past(IO_WDATA_I) == FTM_CFG_EXIT_KEY ? 1'b0 : $past(cfg_mode_q))))
    else $error("configuration mode key not honoured");

  // base high byte readable for the runtime device
  a_base_read: assert property (@(posedge CLOCK_I) disable iff (RST_I) // RULE9
    rd_cfg_dat && ldn_q == FTM_RUNTIME_LDN && cfg_idx_q == FTM_CFG_BASE_HI
      |=> IO_RDATA_O == $past(base_q[15:8]))
    else $error("runtime base high byte not returned");
endmodule

/* tb/ftm_fan_model.sv */
// fan model: tachometer output toggling at a programmable half period
// assumes the bench changes the half period off the clock edge
`timescale 1ns/1ps
module ftm_fan_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] half_i,  // clocks per tach level, zero stops the fan
  output logic            tach_o   // tach level, steady while stopped
);
  logic [7:0] cnt_q;  // clocks spent at the current level

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q  <= 8'h00;
      tach_o <= 1'b0;
    end else if (half_i != 8'h00) begin
      if (cnt_q >= half_i - 8'h01) begin
        cnt_q  <= 8'h00;
        tach_o <= ~tach_o;
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end
endmodule

/* tb/tb_fan_tach_monitor.sv */
// bench for the fan tachometer monitor: host port sequences and fan speeds
// assumes one-cycle host strobes and the fan model on the tach input
`timescale 1ns/1ps
module tb_fan_tach_monitor
  import ftm_pkg::*;
;
  localparam logic [15:0] base = 16'h0A00;  // runtime base, arbitrary
  localparam logic [15:0] ci   = FTM_CFG_INDEX_ADDR;
  localparam logic [15:0] cd   = FTM_CFG_DATA_ADDR;
  localparam logic [15:0] mi   = base + FTM_RUNTIME_MONITOR_OFFSET;
  localparam logic [15:0] md   = base + FTM_RUNTIME_MONITOR_OFFSET + 16'h0001;
  typedef struct packed {
    logic        wr;    // write when set, read and compare otherwise
    logic [15:0] addr;
    logic [7:0]  data;
    logic [7:0]  exp;   // expected read byte
    logic        on;    // expected monitor state after the access
  } ftm_row_s;
  logic        CLOCK_I = 1'b0;
  logic        RST_I   = 1'b1;
  logic [15:0] IO_ADDR_I = 16'h0000;
  logic [7:0]  IO_WDATA_I = 8'h00;
  logic        IO_WR_I = 1'b0;
  logic        IO_RD_I = 1'b0;
  logic        tach;
  logic [7:0]  half = 8'h08;
  logic [7:0]  IO_RDATA_O;
  logic        MONITOR_ON_O;
  logic [7:0]  lo;
  logic [7:0]  hi;
  int          failures = 0;
  int          comparisons = 0;
  int          cycles = 0;
  ftm_row_s    rows [0:18] = '{
    '{1'b1, ci, 8'h55, 8'h00, 1'b0},  // enter
    '{1'b1, ci, 8'h07, 8'h00, 1'b0},
    '{1'b1, cd, 8'h0A, 8'h00, 1'b0},  // device select
    '{1'b1, ci, 8'h60, 8'h00, 1'b0},
    '{1'b0, cd, 8'h00, 8'h0A, 1'b0},  // base high
    '{1'b1, ci, 8'h61, 8'h00, 1'b0},
    '{1'b0, cd, 8'h00, 8'h00, 1'b0},  // base low
    '{1'b1, ci, 8'hAA, 8'h00, 1'b0},  // leave
    '{1'b0, cd, 8'h00, 8'h00, 1'b0},  // data port closed
    '{1'b1, mi, 8'h28, 8'h00, 1'b0},
    '{1'b0, md, 8'h00, 8'hFF, 1'b0},  // stalled low
    '{1'b1, mi, 8'h29, 8'h00, 1'b0},
    '{1'b0, md, 8'h00, 8'hFF, 1'b0},  // stalled high
    '{1'b1, mi, 8'h30, 8'h00, 1'b0},
    '{1'b0, md, 8'h00, 8'h00, 1'b0},  // unmapped index
    '{1'b1, mi, 8'h40, 8'h00, 1'b0},
    '{1'b1, md, 8'h80, 8'h00, 1'b0},  // other bits only
    '{1'b0, md, 8'h00, 8'h80, 1'b0},  // read back
    '{1'b1, md, 8'h81, 8'h00, 1'b1}   // start
  };

  // one core clock per reference period keeps a full stall inside the run budget
  ftm_top #(.RUNTIME_BASE(base), .REF_DIV(1)) i_ftm_top (
    .CLOCK_I      (CLOCK_I),
    .RST_I        (RST_I),
    .IO_ADDR_I    (IO_ADDR_I),
    .IO_WDATA_I   (IO_WDATA_I),
    .IO_WR_I      (IO_WR_I),
    .IO_RD_I      (IO_RD_I),
    .TACH_I       (tach),
    .IO_RDATA_O   (IO_RDATA_O),
    .MONITOR_ON_O (MONITOR_ON_O)
  );

  ftm_fan_model i_ftm_fan_model (
    .clk_i  (CLOCK_I),
    .rst_i  (RST_I),
    .half_i (half),
    .tach_o (tach)
  );

  // 250 MHz clock
  always #2 CLOCK_I = ~CLOCK_I;

  // hang guard
  always @(posedge CLOCK_I) begin
    cycles <= cycles + 1;
    if (cycles == 72000) begin
      failures++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (failures == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // the tick that meets the closing edge may fall outside the window, so one tick either way
  task automatic chk_cnt(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got < exp - 16'h0001 || got > exp + 16'h0001 || $isunknown(got)) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic do_reset();
    @(posedge CLOCK_I);
    RST_I <= 1'b1;
    repeat (3) @(posedge CLOCK_I);
    RST_I <= 1'b0;
  endtask

  task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge CLOCK_I);
    IO_ADDR_I  <= a;
    IO_WDATA_I <= d;
    IO_WR_I    <= 1'b1;
    @(posedge CLOCK_I);
    IO_WR_I <= 1'b0;
  endtask

  // read answer lands one cycle after the strobe edge
  task automatic io_rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge CLOCK_I);
    IO_ADDR_I <= a;
    IO_RD_I   <= 1'b1;
    @(posedge CLOCK_I);
    IO_RD_I <= 1'b0;
    #1 d = IO_RDATA_O;
  endtask

  task automatic mon_rd(input logic [7:0] idx, output logic [7:0] d);
    io_wr(mi, idx);
    io_rd(md, d);
  endtask

  initial begin
    do_reset();
    #1;
    chk8(IO_RDATA_O, 8'h00);
    chk8({7'h00, MONITOR_ON_O}, 8'h00);
    // table of ordinary accesses
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        io_wr(rows[i].addr, rows[i].data);
        #1;
      end else begin
        io_rd(rows[i].addr, lo);
        chk8(lo, rows[i].exp);
      end
      chk8({7'h00, MONITOR_ON_O}, {7'h00, rows[i].on});
    end
    // high byte read first freezes the low byte across a speed change
    repeat (300) @(posedge CLOCK_I);
    mon_rd(FTM_FAN_SPEED_COUNT_HI_INDEX, hi);
    chk8(hi, 8'h00);
    half <= 8'h10;
    repeat (400) @(posedge CLOCK_I);
    mon_rd(FTM_FAN_SPEED_COUNT_INDEX, lo);
    chk_cnt({8'h00, lo}, 16'h0028);
    // released: new value taken, low byte first then high
    repeat (400) @(posedge CLOCK_I);
    mon_rd(FTM_FAN_SPEED_COUNT_INDEX, lo);
    mon_rd(FTM_FAN_SPEED_COUNT_HI_INDEX, hi);
    chk_cnt({hi, lo}, 16'h0050);
    chk_cnt({hi, lo}, 16'h0050);
    // second reset in mid-run restores the stalled value
    do_reset();
    mon_rd(FTM_FAN_SPEED_COUNT_INDEX, lo);
    mon_rd(FTM_FAN_SPEED_COUNT_HI_INDEX, hi);
    chk8(lo & hi, 8'hFF);
    chk8({7'h00, MONITOR_ON_O}, 8'h00);
    // restart after reset: a real measurement replaces the reset value
    io_wr(mi, FTM_MONITOR_START_CONTROL_INDEX);
    io_wr(md, 8'h01);
    repeat (300) @(posedge CLOCK_I);
    mon_rd(FTM_FAN_SPEED_COUNT_INDEX, lo);
    mon_rd(FTM_FAN_SPEED_COUNT_HI_INDEX, hi);
    chk_cnt({hi, lo}, 16'h0050);
    // fan stops: the window saturates and reports all ones
    half <= 8'h00;
    repeat (66000) @(posedge CLOCK_I);
    mon_rd(FTM_FAN_SPEED_COUNT_INDEX, lo);
    mon_rd(FTM_FAN_SPEED_COUNT_HI_INDEX, hi);
    chk8(lo, 8'hFF);
    chk8(hi, 8'hFF);
    wrap_up();
  end
endmodule
